//--- logic/pwm_event_status.v
// sticky event status with raw and masked views
`timescale 1ns/1ns
module pwm_event_status #(
	parameter W = 6
) (
	// clock and reset
	input  wire         clk,
	input  wire         srst,
	// events and software access
	input  wire [W-1:0] evt,
	input  wire [W-1:0] int_en,
	input  wire         clr_wr,
	input  wire [W-1:0] clr_bits,
	// status views
	output reg  [W-1:0] raw_status,
	output reg  [W-1:0] masked_status,
	output reg          irq
);
	wire [W-1:0] next_raw;   // set wins over clear
	assign next_raw = evt | (raw_status & ~(clr_wr ? clr_bits : {W{1'b0}}));

	// sticky status register, write one to clear
	always @(posedge clk) begin
		if (srst) begin
			raw_status    <= {W{1'b0}};
			masked_status <= {W{1'b0}};
			irq           <= 1'b0;
		end else begin
			raw_status    <= next_raw;
			masked_status <= next_raw & int_en;
			irq           <= |(next_raw & int_en);
		end
	end
endmodule

//--- logic/pwm_gen_defs.vh
// constants shared by the pwm generator timebase files
`ifndef PWM_GEN_DEFS_VH
`define PWM_GEN_DEFS_VH

// counter width, number of generators and event field width
`define PWM_CNT_W      16
`define PWM_NUM_GEN    4
`define PWM_EVT_W      6

// event bit positions in status and enable fields
`define EVT_ZERO       0
`define EVT_LOAD       1
`define EVT_A_UP       2
`define EVT_A_DOWN     3
`define EVT_B_UP       4
`define EVT_B_DOWN     5

// trigger enables sit in bits 13:8 of the enable word
`define TRIG_EN_LSB    8
`define IT_EN_W        14

// reset values
`define PWM_LOAD_RST   16'h0000
`define PWM_CMP_RST    16'h0000

`endif

//--- logic/pwm_generator_timebase_control.v
// four pwm generators: configuration, counters, events
`timescale 1ns/1ns
`include "pwm_gen_defs.vh"
module pwm_generator_timebase_control #(
	parameter NG = `PWM_NUM_GEN,
	parameter CW = `PWM_CNT_W
) (
	// clock and reset
	input  wire             clk,
	input  wire             srst,
	// debugger halt and global sync
	input  wire             cpu_halted,
	input  wire             sync_event,
	// configuration write, one bit per generator
	input  wire [NG-1:0]    cfg_wr,
	input  wire [NG-1:0]    cfg_up_down,
	input  wire [NG-1:0]    cfg_sync_mode,
	input  wire [NG-1:0]    cfg_halt_pause_at_zero,
	// generator enable control
	input  wire [NG-1:0]    gen_enable_set,
	input  wire [NG-1:0]    gen_enable_clr,
	// period and pulse width writes
	input  wire [NG-1:0]    prog_wr,
	input  wire [NG*CW-1:0] prog_load,
	input  wire [NG*CW-1:0] prog_cmp_a,
	input  wire [NG*CW-1:0] prog_cmp_b,
	// interrupt/trigger enable and status clear
	input  wire [NG-1:0]    it_en_wr,
	input  wire [NG*14-1:0] it_en_data,
	input  wire [NG-1:0]    clr_wr,
	input  wire [NG*6-1:0]  clr_bits,
	// status out
	output reg  [NG-1:0]    gen_enabled,
	output reg  [NG*CW-1:0] period_readback,
	output reg  [NG*CW-1:0] counter_value,
	output reg  [NG-1:0]    update_pending,
	output wire [NG*6-1:0]  raw_status,
	output wire [NG*6-1:0]  masked_status,
	output wire [NG-1:0]    gen_irq,
	output reg  [NG-1:0]    gen_trig,
	output reg  [NG*2-1:0]  pwm_out
);
	reg  [NG-1:0]    up_down;      // counting mode
	reg  [NG-1:0]    sync_mode;    // update mode
	reg  [NG-1:0]    pause_zero;   // halt behaviour
	reg  [NG*CW-1:0] prog_load_r;  // programmed period
	reg  [NG*CW-1:0] prog_a_r;
	reg  [NG*CW-1:0] prog_b_r;
	reg  [NG*14-1:0] it_en;        // irq bits 5:0, trigger 13:8
	reg  [NG-1:0]    wr_d;         // write seen last cycle
	wire [NG*CW-1:0] cnt_w;
	wire [NG*CW-1:0] load_w;
	wire [NG-1:0]    pend_w;
	wire [NG*6-1:0]  evt_w;
	wire [NG-1:0]    pa_w;
	wire [NG-1:0]    pb_w;
	genvar g;

	// configuration, programmed values and enables
	always @(posedge clk) begin
		if (srst) begin
			up_down     <= {NG{1'b0}};
			sync_mode   <= {NG{1'b0}};
			pause_zero  <= {NG{1'b0}};
			gen_enabled <= {NG{1'b0}};
			prog_load_r <= {NG*CW{1'b0}};
			prog_a_r    <= {NG*CW{1'b0}};
			prog_b_r    <= {NG*CW{1'b0}};
			it_en       <= {NG*14{1'b0}};
			wr_d        <= {NG{1'b0}};
		end else begin
			up_down    <= (cfg_wr & cfg_up_down) | (~cfg_wr & up_down);
			sync_mode  <= (cfg_wr & cfg_sync_mode) | (~cfg_wr & sync_mode);
			pause_zero <= (cfg_wr & cfg_halt_pause_at_zero)
				| (~cfg_wr & pause_zero);
			// config write leaves generator off
			gen_enabled <= (gen_enabled | gen_enable_set)
				& ~gen_enable_clr & ~cfg_wr;
			wr_d <= prog_wr;
			begin : per_gen
				integer i;
				for (i = 0; i < NG; i = i + 1) begin
					if (prog_wr[i]) begin
						prog_load_r[i*CW +: CW] <= prog_load[i*CW +: CW];
						prog_a_r[i*CW +: CW]    <= prog_cmp_a[i*CW +: CW];
						prog_b_r[i*CW +: CW]    <= prog_cmp_b[i*CW +: CW];
					end
					if (it_en_wr[i])
						it_en[i*14 +: 14] <= it_en_data[i*14 +: 14];
				end
			end
		end
	end

	// per generator timebase and status
	generate
		for (g = 0; g < NG; g = g + 1) begin : gen_blk
			pwm_timebase #(
				.CW(CW)
			) u_tb (
				.clk               (clk),
				.srst              (srst),
				.enable            (gen_enabled[g]),
				.up_down           (up_down[g]),
				.sync_mode         (sync_mode[g]),
				.halt_pause_at_zero(pause_zero[g]),
				.cpu_halted        (cpu_halted),
				.sync_event        (sync_event),
				.prog_load         (prog_load_r[g*CW +: CW]),
				.prog_cmp_a        (prog_a_r[g*CW +: CW]),
				.prog_cmp_b        (prog_b_r[g*CW +: CW]),
				.prog_wr           (wr_d[g]),
				.count             (cnt_w[g*CW +: CW]),
				.act_load          (load_w[g*CW +: CW]),
				.pending           (pend_w[g]),
				.evt               (evt_w[g*6 +: 6]),
				.pwm_a             (pa_w[g]),
				.pwm_b             (pb_w[g])
			);
			pwm_event_status #(
				.W(6)
			) u_st (
				.clk          (clk),
				.srst         (srst),
				.evt          (evt_w[g*6 +: 6]),
				.int_en       (it_en[g*14 +: 6]),
				.clr_wr       (clr_wr[g]),
				.clr_bits     (clr_bits[g*6 +: 6]),
				.raw_status   (raw_status[g*6 +: 6]),
				.masked_status(masked_status[g*6 +: 6]),
				.irq          (gen_irq[g])
			);
		end
	endgenerate

	// registered observation and trigger outputs
	always @(posedge clk) begin
		if (srst) begin
			period_readback <= {NG*CW{1'b0}};
			counter_value   <= {NG*CW{1'b0}};
			update_pending  <= {NG{1'b0}};
			gen_trig        <= {NG{1'b0}};
			pwm_out         <= {NG*2{1'b0}};
		end else begin
			period_readback <= prog_load_r;
			counter_value   <= cnt_w;
			update_pending  <= pend_w | wr_d;
			begin : trig_loop
				integer j;
				for (j = 0; j < NG; j = j + 1) begin
					gen_trig[j] <= |(evt_w[j*6 +: 6]
						& it_en[j*14 + `TRIG_EN_LSB +: 6]);
					pwm_out[j*2]   <= pa_w[j];
					pwm_out[j*2+1] <= pb_w[j];
				end
			end
		end
	end
endmodule

//--- logic/pwm_timebase.v
// one generator counter with pending parameters and events
`timescale 1ns/1ns
`include "pwm_gen_defs.vh"
module pwm_timebase #(
	parameter CW = 16
) (
	// clock and reset
	input  wire          clk,
	input  wire          srst,
	// configuration
	input  wire          enable,
	input  wire          up_down,
	input  wire          sync_mode,
	input  wire          halt_pause_at_zero,
	input  wire          cpu_halted,
	input  wire          sync_event,
	// programmed values
	input  wire [CW-1:0] prog_load,
	input  wire [CW-1:0] prog_cmp_a,
	input  wire [CW-1:0] prog_cmp_b,
	input  wire          prog_wr,
	// state
	output reg  [CW-1:0] count,
	output reg  [CW-1:0] act_load,
	output reg           pending,
	output reg  [5:0]    evt,
	output reg           pwm_a,
	output reg           pwm_b
);
	reg          dir_up;      // up/down direction, 1 while rising
	reg          armed;       // sync seen, copy allowed
	reg [CW-1:0] act_a;       // active comparator a
	reg [CW-1:0] act_b;       // active comparator b
	reg [CW-1:0] next_count;
	reg          next_dir;
	wire         at_zero;
	wire         hold;
	wire         run;
	wire         apply;

	assign at_zero = (count == {CW{1'b0}});
	// pause only once the counter sits at zero
	assign hold  = cpu_halted & halt_pause_at_zero & at_zero;
	assign run   = enable & ~hold;
	// copy pending values only at zero
	assign apply = pending & at_zero & (~sync_mode | armed | sync_event);

	// next count and direction
	always @* begin
		next_count = count;
		next_dir   = dir_up;
		if (up_down) begin
			if (at_zero) begin
				next_dir   = 1'b1;
				next_count = (act_load == {CW{1'b0}}) ? count : count + 1'b1;
			end else if (dir_up && count >= act_load) begin
				next_dir   = 1'b0;
				next_count = count - 1'b1;
			end else if (dir_up) begin
				next_count = count + 1'b1;
			end else begin
				next_count = count - 1'b1;
			end
		end else begin
			next_dir   = 1'b0;
			next_count = at_zero ? act_load : count - 1'b1;
		end
	end

	// counter, active registers and events
	always @(posedge clk) begin
		if (srst) begin
			count    <= {CW{1'b0}};
			dir_up   <= 1'b1;
			act_load <= `PWM_LOAD_RST;
			act_a    <= `PWM_CMP_RST;
			act_b    <= `PWM_CMP_RST;
			pending  <= 1'b0;
			armed    <= 1'b0;
			evt      <= 6'h00;
			pwm_a    <= 1'b0;
			pwm_b    <= 1'b0;
		end else begin
			// pending flag: new write wins over apply
			if (prog_wr)
				pending <= 1'b1;
			else if (apply)
				pending <= 1'b0;
			// remember sync event until zero
			if (prog_wr & ~pending)
				armed <= 1'b0;
			else if (apply)
				armed <= 1'b0;
			else if (sync_event & pending)
				armed <= 1'b1;
			if (apply) begin
				act_load <= prog_load;
				act_a    <= prog_cmp_a;
				act_b    <= prog_cmp_b;
			end
			evt <= 6'h00;
			if (run) begin
				count  <= next_count;
				dir_up <= next_dir;
				// events of the new count
				evt[`EVT_ZERO]   <= (next_count == {CW{1'b0}});
				evt[`EVT_LOAD]   <= (next_count == act_load);
				evt[`EVT_A_UP]   <= (next_count == act_a) & next_dir & up_down;
				evt[`EVT_A_DOWN] <= (next_count == act_a) & ~(next_dir & up_down);
				evt[`EVT_B_UP]   <= (next_count == act_b) & next_dir & up_down;
				evt[`EVT_B_DOWN] <= (next_count == act_b) & ~(next_dir & up_down);
				// outputs high while count below comparator
				pwm_a <= (next_count < act_a);
				pwm_b <= (next_count < act_b);
			end
		end
	end
endmodule

//--- verif/pwm_gen_chk.sv
// assertions on generator 0 of the pwm timebase top
`timescale 1ns/1ns
module pwm_gen_chk #(
	parameter NG = 4,
	parameter CW = 16
) (
	// clock and reset
	input wire logic             clk,
	input wire logic             srst,
	// control inputs
	input wire logic [NG-1:0]    cfg_wr,
	input wire logic [NG-1:0]    gen_enable_set,
	input wire logic [NG-1:0]    gen_enable_clr,
	input wire logic [NG-1:0]    prog_wr,
	input wire logic [NG*CW-1:0] prog_load,
	input wire logic [NG-1:0]    clr_wr,
	input wire logic [NG*6-1:0]  clr_bits,
	// observed outputs
	input wire logic [NG-1:0]    gen_enabled,
	input wire logic [NG*CW-1:0] period_readback,
	input wire logic [NG*CW-1:0] counter_value,
	input wire logic [NG-1:0]    update_pending,
	input wire logic [NG*6-1:0]  raw_status,
	input wire logic [NG*6-1:0]  masked_status,
	input wire logic [NG-1:0]    gen_irq,
	input wire logic [NG-1:0]    gen_trig
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// counter sat at zero within the last two cycles
	sequence near_zero;
		counter_value[15:0] == 0 || $past(counter_value[15:0]) == 0
			|| $past(counter_value[15:0], 2) == 0;
	endsequence
	// programmed load shows up two cycles on
	property readback_p;
		logic [15:0] v;
		(prog_wr[0], v = prog_load[15:0]) |-> ##2 period_readback[15:0] == v;
	endproperty
	off_freezes_count_a:
		assert property ((!gen_enabled[0] && !cfg_wr[0] && !prog_wr[0]) [*3]
			|-> $stable(counter_value[15:0])) else $error("count moved");
	cfg_disables_a:
		assert property (cfg_wr[0] |-> ##[1:2] !gen_enabled[0])
			else $error("config left gen on");
	set_enables_a:
		assert property (gen_enable_set[0] && !gen_enable_clr[0] && !cfg_wr[0]
			|-> ##[1:2] gen_enabled[0]) else $error("gen not on");
	zero_write_keeps_a:
		assert property (raw_status[0] && !(clr_wr[0] && clr_bits[0])
			&& !$past(clr_wr[0]) |=> raw_status[0]) else $error("bit lost");
	irq_drops_a:
		assert property (!(|masked_status[5:0]) [*2] |-> !gen_irq[0])
			else $error("irq without source");
	irq_rises_a:
		assert property ((|masked_status[5:0]) [*2] |-> gen_irq[0])
			else $error("irq missing");
	trig_with_event_a:
		assert property (gen_trig[0] |-> |raw_status[5:0])
			else $error("trigger without event");
	apply_at_zero_a:
		assert property ($fell(update_pending[0]) |-> near_zero)
			else $error("update away from zero");
	readback_new_a:
		assert property (readback_p) else $error("readback stale");
endmodule
bind pwm_generator_timebase_control pwm_gen_chk #(.NG(NG), .CW(CW))
	pwm_gen_chk_inst (.clk(clk), .srst(srst), .cfg_wr(cfg_wr),
	.gen_enable_set(gen_enable_set), .gen_enable_clr(gen_enable_clr),
	.prog_wr(prog_wr), .prog_load(prog_load), .clr_wr(clr_wr),
	.clr_bits(clr_bits), .gen_enabled(gen_enabled),
	.period_readback(period_readback), .counter_value(counter_value),
	.update_pending(update_pending), .raw_status(raw_status),
	.masked_status(masked_status), .gen_irq(gen_irq), .gen_trig(gen_trig));

//--- verif/pwm_stage_model.sv
// power stage model: counts turn-on edges of pwm pin 0
`timescale 1ns/1ns
module pwm_stage_model (
	// clock
	input  wire logic        clk,
	// pwm pins from the generators
	input  wire logic [7:0]  pwm_in,
	// turn-on edges seen on pin 0
	output logic      [15:0] on_edges
);
	logic prev = 1'b0; // last sampled level of pin 0
	initial on_edges = 16'h0000;
	// one turn-on per low to high change
	always @(posedge clk) begin
		if (pwm_in[0] && !prev)
			on_edges <= on_edges + 16'h0001;
		prev <= pwm_in[0];
	end
endmodule

//--- verif/tb_pwm_generator_timebase_control.sv
// self-checking bench for the pwm generator timebase
`timescale 1ns/1ns
module tb_pwm_generator_timebase_control;
	logic        clk, srst, cpu_halted, sync_event;
	logic [3:0]  cfg_wr, cfg_up_down, cfg_sync_mode, cfg_halt_pause_at_zero;
	logic [3:0]  gen_enable_set, gen_enable_clr, prog_wr, it_en_wr, clr_wr;
	logic [63:0] prog_load, prog_cmp_a, prog_cmp_b;
	logic [55:0] it_en_data;
	logic [23:0] clr_bits;
	wire  [3:0]  gen_enabled, update_pending, gen_irq, gen_trig;
	wire  [63:0] period_readback, counter_value;
	wire  [23:0] raw_status, masked_status;
	wire  [7:0]  pwm_out;
	wire  [15:0] on_edges;
	int          err_count, n_checks, k, n, t0, per, e0;
	// rows: up/down flag, load, ticks between zero points
	logic [47:0] rows [4] = '{48'h0000_0005_0006, 48'h0001_0005_000a,
		48'h0000_0009_000a, 48'h0001_0003_0006};
	pwm_generator_timebase_control pwm_generator_timebase_control_inst (.*);
	pwm_stage_model pwm_stage_model_inst (.clk(clk), .pwm_in(pwm_out),
		.on_edges(on_edges));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic tick(int c = 1);
		repeat (c) @(posedge clk);
		#1;
	endtask
	task automatic chk(logic [15:0] seen, logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic pulse(ref logic [3:0] s, input logic [3:0] v);
		s = v;
		tick();
		s = 4'h0;
	endtask
	// configure, program and start the chosen generators
	task automatic setup(logic ud, sy, hp, logic [15:0] ld, logic [3:0] g);
		cfg_up_down = {4{ud}};
		cfg_sync_mode = {4{sy}};
		cfg_halt_pause_at_zero = {4{hp}};
		prog_load = {4{ld}};
		pulse(cfg_wr, g);
		pulse(prog_wr, g);
		pulse(gen_enable_set, g);
	endtask
	// next cycle with generator 0 at zero, bounded
	task automatic wait_zero();
		tick();
		for (k = 0; k < 100 && counter_value[15:0] !== 16'h0000; k++)
			tick();
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// watchdog well past the expected run length
	initial begin
		#200000;
		err_count++;
		end_of_test();
	end
	initial begin
		{srst, cfg_wr, gen_enable_set, gen_enable_clr, prog_wr} = 17'h1_0000;
		{cpu_halted, sync_event, it_en_wr, clr_wr, clr_bits} = 34'h0;
		{cfg_up_down, cfg_sync_mode, cfg_halt_pause_at_zero} = 12'h000;
		{prog_load, it_en_data} = 120'h0;
		prog_cmp_a = {4{16'h0002}};
		prog_cmp_b = {4{16'h0001}};
		tick(16);
		srst = 1'b0;
		chk(16'({gen_enabled, counter_value[11:0]}), 16'h0000);
		$display("reset test done");
		// period and one turn-on per period in both counting modes
		foreach (rows[r]) begin
			setup(rows[r][32], 1'b0, 1'b0, rows[r][31:16], 4'h1);
			wait_zero();
			wait_zero();
			t0 = $time;
			e0 = on_edges;
			wait_zero();
			chk(16'(($time - t0) / 40), rows[r][15:0]);
			chk(16'(on_edges - e0), 16'h0001);
			pulse(gen_enable_clr, 4'h1);
			$display("row %0d done", r);
		end
		// frozen while off, counting when on, config switches off
		// counter_value trails the counter by one clock
		tick(2);
		per = counter_value[15:0];
		tick(5);
		chk(counter_value[15:0], 16'(per));
		pulse(gen_enable_set, 4'h1);
		tick(3);
		per = counter_value[15:0];
		tick();
		chk(16'(counter_value[15:0] != 16'(per)), 16'h0001);
		pulse(cfg_wr, 4'h1);
		tick();
		chk(16'(gen_enabled[0]), 16'h0000);
		$display("enable test done");
		// sync mode holds new values until the shared sync event
		setup(1'b0, 1'b1, 1'b0, 16'h0007, 4'h3);
		tick(30);
		chk(16'(update_pending[1:0]), 16'h0003);
		chk(period_readback[15:0], 16'h0007);
		sync_event = 1'b1;
		tick();
		sync_event = 1'b0;
		tick(20);
		chk(16'(update_pending[1:0]), 16'h0000);
		$display("sync test done");
		// events, masking, trigger and clearing on generator 0
		// up/down rows left rising-count bits set; clear them all first
		clr_bits[5:0] = 6'h3f;
		pulse(clr_wr, 4'h1);
		clr_bits[5:0] = 6'h00;
		it_en_data[13:0] = 14'h0101;
		pulse(it_en_wr, 4'h1);
		tick(20);
		chk(16'(raw_status[5:0]), 16'h002b);
		chk(16'(masked_status[5:0]), 16'h0001);
		chk(16'(gen_irq[0]), 16'h0001);
		for (n = 0, k = 0; k < 16; k++) begin
			tick();
			n += gen_trig[0];
		end
		chk(16'(n), 16'h0002);
		it_en_data[13:0] = 14'h0000;
		pulse(it_en_wr, 4'h1);
		for (n = 0, k = 0; k < 16; k++) begin
			tick();
			n += gen_trig[0];
		end
		chk(16'({n[7:0], masked_status[5:0], gen_irq[0]}), 16'h0000);
		pulse(gen_enable_clr, 4'h1);
		tick(3);
		pulse(clr_wr, 4'h1);
		tick(2);
		chk(16'(raw_status[5:0]), 16'h002b);
		clr_bits[5:0] = 6'h01;
		pulse(clr_wr, 4'h1);
		tick(2);
		chk(16'(raw_status[5:0]), 16'h002a);
		$display("status test done");
		// debugger halt: pause at zero, or keep running
		setup(1'b0, 1'b0, 1'b1, 16'h0007, 4'h1);
		cpu_halted = 1'b1;
		tick(30);
		chk(counter_value[15:0], 16'h0000);
		cpu_halted = 1'b0;
		setup(1'b0, 1'b0, 1'b0, 16'h0007, 4'h1);
		cpu_halted = 1'b1;
		tick(20);
		per = counter_value[15:0];
		tick(3);
		chk(16'(counter_value[15:0] != 16'(per)), 16'h0001);
		cpu_halted = 1'b0;
		$display("halt test done");
		end_of_test();
	end
endmodule
